// ### core/aids_blinker.sv
`timescale 1ns/1ps
`default_nettype none

module aids_blinker #(
  parameter int HALF = aids_pkg::BLINK_HALF_CYCLES        // Cycles per half blink period
) (
  input  wire logic clk_sys,                              // System clock
  input  wire logic reset,                                // Synchronous reset, high
  input  wire logic clkEn,                                // Clock enable
  output logic      blink                                 // Square wave at blink rate
);

  localparam int CW = $clog2(HALF);

  logic [CW-1:0] cnt_q, cnt_d;     // Half period counter
  logic          ph_q, ph_d;       // Phase

  // Next-state: toggle phase each half period
  always_comb begin
    cnt_d = cnt_q + CW'(1);
    ph_d  = ph_q;
    if (cnt_q == CW'(HALF - 1)) begin
      cnt_d = '0;
      ph_d  = ~ph_q;
    end
  end

  // Register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
      ph_q  <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
      ph_q  <= ph_d;
    end
  end

  assign blink = ph_q;

endmodule : aids_blinker

`default_nettype wire

// ### core/aids_diag_status.sv
// Operation
// R1: Record reports eight diagnostic bits per channel
// R2: Record reports two channels
// R3: Summary bit per channel group error
// R4: Channel byte bit0 parameterization error
// R5: Bit1 raw above, bit2 raw below
// R6: Bit4 sensor supply error, bit3 reserved
// R7: Bit5 process interrupt lost
// R8: Bit6 range underflow, bit7 range overflow
// R9: Timestamp captures ticker at diagnostic event
// R10: Ticker starts at zero, counts microseconds
// R11: Ticker 32 bits, wraps to zero
// R12: Run indicator off without bus communication
// R13: Fault indicator lit on module error
// R14: Both off means bus supply error
// R15: Configuration error blinks fault at 2 Hz
// R16: Channel indicator on range or parameter fault; here lit one cycle only, until the same fault opens the window
// R17: No output image bytes used
// R18: Input image: ch0 offset 0, ch1 offset 2
// R19: Fault lit from first incoming to last going
`timescale 1ns/1ps
`default_nettype none

module aids_diag_status #(
  parameter int TICK_CYCLES = aids_pkg::TICK_CYCLES,      // Cycles per microsecond
  parameter int BLINK_HALF  = aids_pkg::BLINK_HALF_CYCLES  // Half blink period in cycles
) (
  input  wire logic                           clk_sys,       // System clock 50 MHz
  input  wire logic                           reset,         // Synchronous reset, high
  input  wire logic                           clkEn,         // Clock enable, freezes state
  // Front end, same clock domain
  input  wire logic [15:0]                    analogIn0,     // Channel 0 conversion result
  input  wire logic [15:0]                    analogIn1,     // Channel 1 conversion result
  input  wire aids_pkg::aids_chan_cond_type   cond0,         // Channel 0 conditions
  input  wire aids_pkg::aids_chan_cond_type   cond1,         // Channel 1 conditions
  // External status pins, asynchronous
  input  wire logic                           busCommOk,     // Bus communication possible
  input  wire logic                           busPowerOk,    // Bus power supply good
  input  wire logic                           configErr,     // Configuration error
  input  wire logic                           moduleErr,     // Module-level error
  // Backplane input image
  input  wire logic [1:0]                     imgAddr,       // Input image byte address
  output logic      [7:0]                     imgData,       // Input image byte
  // Diagnostic record read port
  input  wire logic [4:0]                     recAddr,       // Record byte index
  output logic      [7:0]                     recData,       // Record byte
  output logic                                diagActive,    // Diagnostic window open
  // Indicators
  output aids_pkg::aids_led_type              leds           // Status indicators
);

  // R17: the block has no output image port at all

  // Pin synchronisers, two flops each
  logic [3:0] sync1_q, sync2_q;    // Stage one only feeds stage two
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (clkEn) begin
      sync1_q <= {moduleErr, configErr, busPowerOk, busCommOk};
      sync2_q <= sync1_q;
    end
  end

  logic commOk, pwrOk, cfgErr, modErr;
  assign commOk = sync2_q[0];
  assign pwrOk  = sync2_q[1];
  assign cfgErr = sync2_q[2];
  assign modErr = sync2_q[3];

  // Ticker and blink source
  logic [31:0] usNow;              // Current microsecond count
  logic        blinkPh;            // 2 Hz square wave

  aids_us_ticker #(.CYCLES(TICK_CYCLES)) uTicker (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .usCount (usNow)
  );

  aids_blinker #(.HALF(BLINK_HALF)) uBlink (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .blink   (blinkPh)
  );

  // Build a channel error byte from its conditions
  function automatic logic [7:0] errByte(input aids_pkg::aids_chan_cond_type c);
    logic [7:0] b;
    b = 8'h00;                                        // Bit 3 stays reserved, R6
    b[aids_pkg::ERR_BIT_PARAM]     = c.paramErr;      // R4
    b[aids_pkg::ERR_BIT_RAW_HIGH]  = c.rawHigh;       // R5
    b[aids_pkg::ERR_BIT_RAW_LOW]   = c.rawLow;        // R5
    b[aids_pkg::ERR_BIT_SUPPLY]    = c.supplyErr;     // R6
    b[aids_pkg::ERR_BIT_IRQ_LOST]  = c.irqLost;       // R7
    b[aids_pkg::ERR_BIT_UNDERFLOW] = c.underflow;     // R8
    b[aids_pkg::ERR_BIT_OVERFLOW]  = c.overflow;      // R8
    return b;
  endfunction : errByte

  // Diagnostic state
  logic [7:0]  channel_zero_error_flags_q, channel_zero_error_flags_d;  // Channel 0 error byte
  logic [7:0]  channel_one_error_flags_q, channel_one_error_flags_d;  // Channel 1 error byte
  logic [31:0] stamp_q,  stamp_d;   // Event timestamp
  logic        active_q, active_d;  // Window between incoming and going

  logic [7:0] new0, new1;
  logic       anyNow;
  assign new0   = errByte(cond0);
  assign new1   = errByte(cond1);
  assign anyNow = (new0 != 8'h00) || (new1 != 8'h00);

  // Window logic: the record freezes while the window is open, so later
  // events inside it are dropped, matching the incoming/going model
  always_comb begin
    channel_zero_error_flags_d = channel_zero_error_flags_q;
    channel_one_error_flags_d = channel_one_error_flags_q;
    stamp_d  = stamp_q;
    active_d = active_q;
    if (!active_q && anyNow) begin
      // Incoming event: capture flags and ticker together
      channel_zero_error_flags_d = new0;
      channel_one_error_flags_d = new1;
      stamp_d  = usNow;                               // R9
      active_d = 1'b1;                                // R19
    end else if (active_q && !anyNow) begin
      // Going event: every cause has cleared
      channel_zero_error_flags_d = 8'h00;
      channel_one_error_flags_d = 8'h00;
      active_d = 1'b0;                                // R19
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      channel_zero_error_flags_q <= 8'h00;
      channel_one_error_flags_q <= 8'h00;
      stamp_q  <= 32'h0;
      active_q <= 1'b0;
    end else if (clkEn) begin
      channel_zero_error_flags_q <= channel_zero_error_flags_d;
      channel_one_error_flags_q <= channel_one_error_flags_d;
      stamp_q  <= stamp_d;
      active_q <= active_d;
    end
  end

  // Record byte mux, combinational part
  logic [7:0] rec_d;
  always_comb begin
    case (recAddr)
      aids_pkg::REC_BITS_PER_CH:   rec_d = aids_pkg::DIAG_BITS_PER_CHANNEL;          // R1
      aids_pkg::REC_CH_COUNT:      rec_d = aids_pkg::CHANNEL_COUNT;                  // R2
      aids_pkg::REC_GROUP_SUMMARY: rec_d = {6'h00, channel_one_error_flags_q != 8'h00, channel_zero_error_flags_q != 8'h00}; // R3
      aids_pkg::REC_CH0_FLAGS:     rec_d = channel_zero_error_flags_q;
      aids_pkg::REC_CH1_FLAGS:     rec_d = channel_one_error_flags_q;
      aids_pkg::REC_STAMP_FIRST:         rec_d = stamp_q[7:0];                      // R9
      aids_pkg::REC_STAMP_FIRST + 5'h1:  rec_d = stamp_q[15:8];
      aids_pkg::REC_STAMP_FIRST + 5'h2:  rec_d = stamp_q[23:16];
      aids_pkg::REC_STAMP_FIRST + 5'h3:  rec_d = stamp_q[31:24];
      default:                     rec_d = aids_pkg::RESERVED_BYTE;  // Unused and beyond
    endcase
  end

  // Input image mux, little-endian within each value
  logic [7:0] img_d;
  always_comb begin
    case (imgAddr)
      aids_pkg::IMG_OFFS_CH0:        img_d = analogIn0[7:0];                         // R18
      aids_pkg::IMG_OFFS_CH0 + 2'h1: img_d = analogIn0[15:8];
      aids_pkg::IMG_OFFS_CH1:        img_d = analogIn1[7:0];                         // R18
      default:                       img_d = analogIn1[15:8];
    endcase
  end

  // LED decisions
  aids_pkg::aids_led_type led_d;
  logic faultLit;
  assign faultLit = modErr || active_q;                                              // R13 R19
  always_comb begin
    led_d.run = commOk && pwrOk;                                                     // R12 R14
    if (cfgErr) begin
      led_d.fault = blinkPh;                                                         // R15
    end else begin
      led_d.fault = faultLit && pwrOk;                                               // R14
    end
    // Channel lamps only in the run-lit, fault-off state
    led_d.chanFault[0] = led_d.run && !faultLit && !cfgErr &&
                         (cond0.underflow || cond0.overflow || cond0.paramErr);      // R16
    led_d.chanFault[1] = led_d.run && !faultLit && !cfgErr &&
                         (cond1.underflow || cond1.overflow || cond1.paramErr);      // R16
  end

  // Output registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      recData    <= 8'h00;
      imgData    <= 8'h00;
      diagActive <= 1'b0;
      leds       <= '0;
    end else if (clkEn) begin
      recData    <= rec_d;
      imgData    <= img_d;
      diagActive <= active_q;
      leds       <= led_d;
    end
  end

endmodule : aids_diag_status

`default_nettype wire

// ### core/aids_pkg.sv
package aids_pkg;

  // Record constants
  localparam logic [7:0]  DIAG_BITS_PER_CHANNEL = 8'h08;   // Fixed diagnostic bits per channel
  localparam logic [7:0]  CHANNEL_COUNT         = 8'h02;   // Fixed channel count
  localparam logic [7:0]  RESERVED_BYTE         = 8'h00;   // Reserved bytes read as zero
  localparam int          NUM_UNUSED_BYTES      = 6;       // Unused channel error bytes

  // Input image byte offsets
  localparam logic [1:0]  IMG_OFFS_CH0          = 2'h0;    // Channel 0 value offset
  localparam logic [1:0]  IMG_OFFS_CH1          = 2'h2;    // Channel 1 value offset

  // Record byte index in the diagnostic record port
  localparam logic [4:0]  REC_BITS_PER_CH       = 5'h00;   // Bits per channel byte
  localparam logic [4:0]  REC_CH_COUNT          = 5'h01;   // Channel count byte
  localparam logic [4:0]  REC_GROUP_SUMMARY     = 5'h02;   // Group summary byte
  localparam logic [4:0]  REC_CH0_FLAGS         = 5'h03;   // Channel 0 error byte
  localparam logic [4:0]  REC_CH1_FLAGS         = 5'h04;   // Channel 1 error byte
  localparam logic [4:0]  REC_UNUSED_FIRST      = 5'h05;   // First unused byte
  localparam logic [4:0]  REC_STAMP_FIRST       = 5'h0B;   // Timestamp byte 0

  // Channel error byte fields
  localparam int          ERR_BIT_PARAM         = 0;       // Parameterization error
  localparam int          ERR_BIT_RAW_HIGH      = 1;       // Raw value above range
  localparam int          ERR_BIT_RAW_LOW       = 2;       // Raw value below range
  localparam int          ERR_BIT_SUPPLY        = 4;       // Sensor supply error
  localparam int          ERR_BIT_IRQ_LOST      = 5;       // Process interrupt lost
  localparam int          ERR_BIT_UNDERFLOW     = 6;       // Measuring range underflow
  localparam int          ERR_BIT_OVERFLOW      = 7;       // Measuring range overflow

  // Timing
  localparam int          CLK_HZ                = 50_000_000;          // System clock rate
  localparam int          TICK_NS               = 1000;                // Ticker period in ns
  localparam int          CLK_NS                = 1_000_000_000 / CLK_HZ;
  localparam int          TICK_CYCLES           = TICK_NS / CLK_NS;    // Cycles per microsecond
  localparam int          BLINK_HZ              = 2;                   // Fault blink rate
  localparam int          BLINK_HALF_CYCLES     = CLK_HZ / (2 * BLINK_HZ); // Half blink period

  // Per-channel condition inputs from the front end
  typedef struct packed {
    logic paramErr;     // Parameterization error
    logic rawHigh;      // Raw value above range
    logic rawLow;       // Raw value below range
    logic supplyErr;    // Sensor supply error
    logic irqLost;      // Process interrupt lost
    logic underflow;    // Measuring range underflow
    logic overflow;     // Measuring range overflow
  } aids_chan_cond_type;

  // LED group
  typedef struct packed {
    logic       run;       // Green run indicator
    logic       fault;     // Red module fault indicator
    logic [1:0] chanFault; // Red channel indicators
  } aids_led_type;

endpackage : aids_pkg

// ### core/aids_us_ticker.sv
`timescale 1ns/1ps
`default_nettype none

module aids_us_ticker #(
  parameter int CYCLES = aids_pkg::TICK_CYCLES            // Clock cycles per microsecond
) (
  input  wire logic        clk_sys,                       // System clock
  input  wire logic        reset,                         // Synchronous reset, high
  input  wire logic        clkEn,                         // Clock enable
  output logic      [31:0] usCount                        // Microsecond count
);

  localparam int PW = $clog2(CYCLES);

  logic [PW-1:0] pre_q, pre_d;     // Prescaler
  logic [31:0]   cnt_q, cnt_d;     // Ticker

  // Next-state: prescale to 1 us, 32-bit count wraps to zero naturally
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (pre_q == PW'(CYCLES - 1)) begin
      pre_d = '0;
      cnt_d = cnt_q + 32'h1;       // R10 R11
    end else begin
      pre_d = pre_q + PW'(1);
    end
  end

  // Register; reset stands for power-on so count starts at zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pre_q <= '0;
      cnt_q <= 32'h0;              // R10
    end else if (clkEn) begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  assign usCount = cnt_q;

endmodule : aids_us_ticker

`default_nettype wire

// ### dv/aids_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

// Backplane master stand-in: reads single bytes of image or record
module aids_bus_master (
  input  wire logic       clk_sys,  // System clock
  input  wire logic [7:0] imgData,  // Image byte from device
  input  wire logic [7:0] recData,  // Record byte from device
  output logic      [1:0] imgAddr,  // Image byte address
  output logic      [4:0] recAddr   // Record byte index
);
  initial begin
    imgAddr = 2'h0;
    recAddr = 5'h00;
  end

  // Address moves off the sampling edge, data taken one cycle later
  task automatic rd(input logic img, input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    if (img) imgAddr = a[1:0];
    else recAddr = a;
    @(negedge clk_sys);  // Answer registered at the edge between
    d = img ? imgData : recData;
  endtask : rd
endmodule : aids_bus_master

`default_nettype wire

// ### dv/aids_diag_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module aids_diag_status_monitor #(
  parameter int BLINK_HALF = 4  // Half blink period in cycles
) (
  input wire logic                         clk_sys,    // System clock
  input wire logic                         reset,      // Synchronous reset
  input wire logic                         clkEn,      // Clock enable
  input wire logic [15:0]                  analogIn0,  // Channel 0 value
  input wire logic [15:0]                  analogIn1,  // Channel 1 value
  input wire aids_pkg::aids_chan_cond_type cond0,      // Channel 0 conditions
  input wire aids_pkg::aids_chan_cond_type cond1,      // Channel 1 conditions
  input wire logic                         busCommOk,  // Bus communication
  input wire logic                         busPowerOk, // Bus power
  input wire logic                         configErr,  // Configuration error
  input wire logic                         moduleErr,  // Module error
  input wire logic [1:0]                   imgAddr,    // Image address
  input wire logic [7:0]                   imgData,    // Image byte
  input wire logic [4:0]                   recAddr,    // Record index
  input wire logic [7:0]                   recData,    // Record byte
  input wire logic                         diagActive, // Window open
  input wire aids_pkg::aids_led_type       leds        // Indicators
);
  localparam int BLW = BLINK_HALF + 3;  // Slack for sync flops

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Pins pass two sync flops and an output register, hence four samples
  a_bits_per_ch: assert property (clkEn && !$past(reset) && recAddr == 5'h00 |=> recData == 8'h08)
    else $error("bits per channel byte wrong");
  a_chan_count: assert property (clkEn && !$past(reset) && recAddr == 5'h01 |=> recData == 8'h02)
    else $error("channel count byte wrong");
  a_img_ch0_low: assert property (clkEn && !$past(reset) && imgAddr == 2'h0 |=> imgData == $past(analogIn0[7:0]))
    else $error("image byte 0 wrong");
  a_img_ch1_high: assert property (clkEn && !$past(reset) && imgAddr == 2'h3 |=> imgData == $past(analogIn1[15:8]))
    else $error("image byte 3 wrong");
  a_run_off_nocomm: assert property ((!busCommOk && clkEn)[*4] |-> !leds.run)
    else $error("run lit without bus");
  a_fault_on_moderr: assert property ((moduleErr && busPowerOk && !configErr && clkEn)[*4] |-> leds.fault)
    else $error("fault dark on module error");
  a_both_off_power: assert property ((!busPowerOk && !configErr && clkEn)[*4] |-> !leds.run && !leds.fault)
    else $error("indicator lit without bus power");
  a_config_blinks: assert property ((configErr && clkEn)[*4] |-> ##[1:BLW] $changed(leds.fault))
    else $error("fault not blinking");
  a_chan_led_cause: assert property (leds.chanFault[0] && $past(clkEn) |-> $past(cond0.overflow || cond0.underflow || cond0.paramErr))
    else $error("channel indicator without cause");
  a_window_fault: assert property ((diagActive && busPowerOk && !configErr && clkEn)[*4] |-> leds.fault)
    else $error("fault dark in window");

  c_window: cover property ($rose(diagActive));
  c_blink: cover property (configErr && $fell(leds.fault));
  c_nopower: cover property (!busPowerOk && !leds.run);
endmodule : aids_diag_status_monitor

bind aids_diag_status aids_diag_status_monitor #(.BLINK_HALF(BLINK_HALF)) u_mon (.*);

`default_nettype wire

// ### dv/analog_input_diag_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module analog_input_diag_status_tb;
  typedef struct {logic img; logic [4:0] a; logic [7:0] e;} aids_row_type;
  logic                         clk_sys = 1'b0;  // 50 MHz clock
  logic                         reset, clkEn;    // Control
  logic [15:0]                  analogIn0, analogIn1;
  aids_pkg::aids_chan_cond_type cond0, cond1;    // Front end conditions
  logic                         busCommOk, busPowerOk, configErr, moduleErr;
  logic [1:0]                   imgAddr;         // Driven by master model
  logic [4:0]                   recAddr;         // Driven by master model
  logic [7:0]                   imgData, recData, d;
  logic                         diagActive;
  aids_pkg::aids_led_type       leds;
  logic [31:0]                  stamp;           // Assembled timestamp
  int                           num_errors = 0, checks_done = 0, cyc = 0, c0, n;
  // Expected error byte per condition bit, overflow first
  logic [7:0] errTab [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
  aids_row_type rows [10] = '{'{0, 0, 8'h08}, '{0, 1, 8'h02}, '{0, 5, 8'h00}, '{0, 10, 8'h00},
    '{0, 15, 8'h00}, '{0, 31, 8'h00}, '{1, 0, 8'h5A}, '{1, 1, 8'hA5}, '{1, 2, 8'hC3}, '{1, 3, 8'h3C}};

  always #10 clk_sys = ~clk_sys;
  // Cycles since release, the ticker's time base
  always @(posedge clk_sys) if (!reset) cyc <= cyc + 1;

  aids_diag_status #(.TICK_CYCLES(50), .BLINK_HALF(4)) DUT (.*);
  aids_bus_master bm (.clk_sys(clk_sys), .imgData(imgData), .recData(recData),
    .imgAddr(imgAddr), .recAddr(recAddr));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Bounded wait for the window flag
  task automatic wait_flag(input logic v);
    for (int k = 0; k < 20 && diagActive !== v; k++) @(negedge clk_sys);
    `CHK("diagActive", v, diagActive)
  endtask : wait_flag

  // Pin levels, then indicators after the sync delay
  task automatic led(input logic [3:0] pins, input logic [1:0] e);
    {busCommOk, busPowerOk, moduleErr, configErr} = pins;
    repeat (5) @(negedge clk_sys);
    `CHK("run fault", e, {leds.run, leds.fault})
  endtask : led

  initial begin
    {reset, clkEn, busCommOk, busPowerOk, configErr, moduleErr} = 6'b111100;
    {analogIn0, analogIn1} = {16'hA55A, 16'h3CC3};
    {cond0, cond1} = '0;
    repeat (8) @(negedge clk_sys);
    `CHK("recData in reset", 8'h00, recData)
    reset = 1'b0;
    foreach (rows[i]) begin
      bm.rd(rows[i].img, rows[i].a, d);
      `CHK("row", rows[i].e, d)
    end
    $display("table test done");
    // Every condition bit on channel 0, mirrored order on channel 1
    for (int i = 0; i < 7; i++) begin
      c0 = cyc;
      cond0 = 7'(1 << i);
      cond1 = 7'(1 << (6 - i));
      wait_flag(1'b1);
      `CHK("chan lamps", 2'b00, leds.chanFault)
      bm.rd(0, 3, d);
      `CHK("ch0 byte", errTab[i], d)
      bm.rd(0, 4, d);
      `CHK("ch1 byte", errTab[6 - i], d)
      bm.rd(0, 2, d);
      `CHK("summary", 8'h03, d)
      for (int b = 0; b < 4; b++) begin
        bm.rd(0, 5'(11 + b), d);
        stamp[8*b +: 8] = d;
      end
      `CHK("stamp range", 1'b1, (stamp + 1 >= c0 / 50) && (stamp <= c0 / 50 + 1))
      {cond0, cond1} = '0;
      wait_flag(1'b0);
      bm.rd(0, 3, d);
      `CHK("ch0 cleared", 8'h00, d)
    end
    $display("diag test done");
    led(4'b1100, 2'b10);
    led(4'b0100, 2'b00);
    led(4'b1110, 2'b11);
    led(4'b0110, 2'b01);
    led(4'b1000, 2'b00);
    // Blink half period measured between two toggles
    {busCommOk, busPowerOk, moduleErr, configErr} = 4'b1101;
    repeat (6) @(negedge clk_sys);
    d[0] = leds.fault;
    for (int k = 0; k < 20 && leds.fault === d[0]; k++) @(negedge clk_sys);
    n = 0;
    d[0] = leds.fault;
    for (int k = 0; k < 20 && leds.fault === d[0]; k++) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("blink half", 4, n)
    $display("led test done");
    finish_test();
  end

  // Whole run is a few hundred cycles, so this only trips on a hang
  initial begin
    #(20 * 5000);
    num_errors++;
    finish_test();
  end
endmodule : analog_input_diag_status_tb

`default_nettype wire
